// ### p1m_pin_function_select.sv
// p1m_pin_function_select: function select for port-1 pins 0 and 1, plus pin routing of the
// two pulse outputs and the spi signals, with an AXI4-Lite register slave.
// assumes pin inputs are asynchronous; peripheral signals share sys_clk_i.
//
// Notes on behaviour
// [R1] pin0 bit5 routes pin to standard receive
// [R2] pin1 bit5 drives pin from standard transmit
// [R3] pin0 bit6 routes pin to lin receive
// [R4] pin1 bit6 drives pin from lin transmit
// [R5] bit0 enables general io, off after reset
// [R6] pin0 function register at A058, resets zero
// [R7] pin1 function register at A059, resets zero
// [R8] software writes A0, 06, 20 for standard port
// [R9] software writes A0, 06, 40 for lin port
// [R10] software configures pins before using serial port
// [R11] pulse output a on one of five pins
// [R12] pulse output b on one of five pins
// [R13] spi signals each on own candidate pins
// [R14] one enable per pin; reserved bits read zero
`timescale 1ns/100ps
module p1m_pin_function_select
  import p1m_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [AXI_DW-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [AXI_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // port-1 pins 0 and 1
  input wire logic p1_pin0_i,
  output p1m_pin_drive_s p1_pin0_o,
  input wire logic p1_pin1_i,
  output p1m_pin_drive_s p1_pin1_o,
  // peripheral side
  output logic std_serial_rx_o,
  input wire logic std_serial_tx_i,
  output logic lin_serial_rx_o,
  input wire logic lin_serial_tx_i,
  input wire logic [1:0] gpio_out_i,
  input wire logic [1:0] gpio_oe_i,
  output logic [1:0] gpio_in_o,
  output logic [1:0] touch_sense_o,
  input wire logic pulse_output_a_i,
  input wire logic pulse_output_b_i,
  output logic [N_PWM_A-1:0] pulse_a_pins_o,
  output logic [N_PWM_A-1:0] pulse_a_oe_o,
  output logic [N_PWM_B-1:0] pulse_b_pins_o,
  output logic [N_PWM_B-1:0] pulse_b_oe_o,
  input wire logic spi_sck_i,
  input wire logic spi_mosi_i,
  output logic [N_SCK-1:0] spi_sck_pins_o,
  output logic [N_SCK-1:0] spi_sck_oe_o,
  output logic [N_MOSI-1:0] spi_mosi_pins_o,
  output logic [N_MOSI-1:0] spi_mosi_oe_o,
  input wire logic [N_MISO-1:0] spi_miso_pins_i,
  output logic spi_miso_o,
  input wire logic [N_SSN-1:0] spi_ssn_n_pins_i,
  output logic spi_ssn_n_o
);

  localparam int NSYNC = 2 + N_MISO + N_SSN;

  // register state
  logic [7:0] pin0_fn_q, pin0_fn_d;
  logic [7:0] pin1_fn_q, pin1_fn_d;
  logic [31:0] route_sel_q, route_sel_d;
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [AXI_AW-1:0] waddr_q, waddr_d;
  logic [AXI_DW-1:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [AXI_DW-1:0] rdata_q, rdata_d;

  // routing state
  logic [NSYNC-1:0] sync1_q, sync2_q;
  p1m_route_e route0, route1;
  p1m_pin_drive_s pin0_q, pin0_d, pin1_q, pin1_d;
  logic std_rx_q, std_rx_d, lin_rx_q, lin_rx_d;
  logic [1:0] gpio_in_q, gpio_in_d, touch_q, touch_d;
  logic miso_q, miso_d, ssn_n_q, ssn_n_d;
  logic [N_PWM_A-1:0] pa_en_d, pa_en_q;
  logic [N_PWM_B-1:0] pb_en_d, pb_en_q;
  logic [N_SCK-1:0] sck_en_d, sck_en_q;
  logic [N_MOSI-1:0] mosi_en_d, mosi_en_q;
  logic pa_q, pb_q, sck_q, mosi_q;

  logic [AXI_AW-1:0] widx, ridx;
  logic wr_fire;

  assign widx = {2'h0, waddr_q[AXI_AW-1:2]};
  assign ridx = {2'h0, s_axi_araddr_i[AXI_AW-1:2]};
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

  assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_o = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;

  // bus slave and register file
  always_comb
  begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    pin0_fn_d = pin0_fn_q;
    pin1_fn_d = pin1_fn_q;
    route_sel_d = route_sel_q;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_hold_d = 1'b1;
      waddr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata_i;
      wstrb_d = s_axi_wstrb_i;
    end
    if (wr_fire)
    begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      // reserved bits are dropped on write so they read back zero
      if (widx == IDX_PIN0_FUNC) // R6
      begin
        if (wstrb_q[0])
          pin0_fn_d = wdata_q[7:0] & FN_MASK; // R14
      end
      else if (widx == IDX_PIN1_FUNC) // R7
      begin
        if (wstrb_q[0])
          pin1_fn_d = wdata_q[7:0] & FN_MASK; // R14
      end
      else if (widx == IDX_ROUTE_SEL)
      begin
        for (int b = 0; b < 4; b++)
          if (wstrb_q[b])
            route_sel_d[8*b +: 8] = wdata_q[8*b +: 8] & RS_MASK[8*b +: 8];
      end
      else if (widx != IDX_ROUTE_STAT)
        bresp_d = RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready_i)
      bvalid_d = 1'b0;
    if (rvalid_q && s_axi_rready_i)
      rvalid_d = 1'b0;
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      if (ridx == IDX_PIN0_FUNC)
        rdata_d[7:0] = pin0_fn_q;
      else if (ridx == IDX_PIN1_FUNC)
        rdata_d[7:0] = pin1_fn_q;
      else if (ridx == IDX_ROUTE_SEL)
        rdata_d = route_sel_q;
      else if (ridx == IDX_ROUTE_STAT)
        rdata_d[3:0] = {route1, route0};
      else
        rresp_d = RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      pin0_fn_q <= FN_RESET; // R5 R6
      pin1_fn_q <= FN_RESET; // R5 R7
      route_sel_q <= RS_RESET;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      pin0_fn_q <= pin0_fn_d;
      pin1_fn_q <= pin1_fn_d;
      route_sel_q <= route_sel_d;
    end
  end

  // pin function decode; if software sets several enables, standard wins, then lin, then io
  function automatic p1m_route_e fn_route(input logic [7:0] fn);
    if (fn[FN_STD_BIT])
      return RT_STD;
    else if (fn[FN_LIN_BIT])
      return RT_LIN;
    else if (fn[FN_GPIO_BIT])
      return RT_GPIO;
    else
      return RT_TOUCH;
  endfunction

  assign route0 = fn_route(pin0_fn_q);
  assign route1 = fn_route(pin1_fn_q);

  // one-hot candidate enables, out-of-range select leaves every candidate undriven
  genvar i;
  generate
    for (i = 0; i < N_PWM_A; i++)
    begin : g_pwm
      assign pa_en_d[i] = (route_sel_q[RS_PWM_A_LSB +: 3] == 3'(i)); // R11
      assign pb_en_d[i] = (route_sel_q[RS_PWM_B_LSB +: 3] == 3'(i)); // R12
    end
    for (i = 0; i < N_SCK; i++)
    begin : g_sck
      assign sck_en_d[i] = (route_sel_q[RS_SCK_LSB +: 3] == 3'(i)); // R13
    end
    for (i = 0; i < N_MOSI; i++)
    begin : g_mosi
      assign mosi_en_d[i] = (route_sel_q[RS_MOSI_LSB +: 2] == 2'(i)); // R13
    end
  endgenerate

  // pin inputs, peripheral inputs and pin drives
  always_comb
  begin
    std_rx_d = 1'b1;
    lin_rx_d = 1'b1;
    gpio_in_d = 2'h0;
    touch_d = 2'h0;
    pin0_d = '{out: 1'b0, oe: 1'b0};
    pin1_d = '{out: 1'b0, oe: 1'b0};
    unique case (route0)
      RT_STD: std_rx_d = sync2_q[0]; // R1
      RT_LIN: lin_rx_d = sync2_q[0]; // R3
      RT_GPIO:
      begin
        gpio_in_d[0] = sync2_q[0]; // R5
        pin0_d = '{out: gpio_out_i[0], oe: gpio_oe_i[0]};
      end
      RT_TOUCH: touch_d[0] = sync2_q[0];
    endcase
    unique case (route1)
      RT_STD: pin1_d = '{out: std_serial_tx_i, oe: 1'b1}; // R2
      RT_LIN: pin1_d = '{out: lin_serial_tx_i, oe: 1'b1}; // R4
      RT_GPIO:
      begin
        gpio_in_d[1] = sync2_q[1]; // R5
        pin1_d = '{out: gpio_out_i[1], oe: gpio_oe_i[1]};
      end
      RT_TOUCH: touch_d[1] = sync2_q[1];
    endcase
    miso_d = 1'b0;
    ssn_n_d = 1'b1;
    for (int k = 0; k < N_MISO; k++)
      if (route_sel_q[RS_MISO_LSB +: 2] == 2'(k))
        miso_d = sync2_q[2 + k]; // R13
    for (int k = 0; k < N_SSN; k++)
      if (route_sel_q[RS_SSN_LSB +: 2] == 2'(k))
        ssn_n_d = sync2_q[2 + N_MISO + k]; // R13
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      pin0_q <= '0;
      pin1_q <= '0;
      std_rx_q <= 1'b1;
      lin_rx_q <= 1'b1;
      gpio_in_q <= 2'h0;
      touch_q <= 2'h0;
      miso_q <= 1'b0;
      ssn_n_q <= 1'b1;
      pa_en_q <= '0;
      pb_en_q <= '0;
      sck_en_q <= '0;
      mosi_en_q <= '0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {spi_ssn_n_pins_i, spi_miso_pins_i, p1_pin1_i, p1_pin0_i};
      sync2_q <= sync1_q;
      pin0_q <= pin0_d;
      pin1_q <= pin1_d;
      std_rx_q <= std_rx_d;
      lin_rx_q <= lin_rx_d;
      gpio_in_q <= gpio_in_d;
      touch_q <= touch_d;
      miso_q <= miso_d;
      ssn_n_q <= ssn_n_d;
      pa_en_q <= pa_en_d;
      pb_en_q <= pb_en_d;
      sck_en_q <= sck_en_d;
      mosi_en_q <= mosi_en_d;
      pa_q <= pulse_output_a_i;
      pb_q <= pulse_output_b_i;
      sck_q <= spi_sck_i;
      mosi_q <= spi_mosi_i;
    end
  end

  assign p1_pin0_o = pin0_q;
  assign p1_pin1_o = pin1_q;
  assign std_serial_rx_o = std_rx_q;
  assign lin_serial_rx_o = lin_rx_q;
  assign gpio_in_o = gpio_in_q;
  assign touch_sense_o = touch_q;
  assign spi_miso_o = miso_q;
  assign spi_ssn_n_o = ssn_n_q;
  assign pulse_a_oe_o = pa_en_q;
  assign pulse_a_pins_o = pa_en_q & {N_PWM_A{pa_q}};
  assign pulse_b_oe_o = pb_en_q;
  assign pulse_b_pins_o = pb_en_q & {N_PWM_B{pb_q}};
  assign spi_sck_oe_o = sck_en_q;
  assign spi_sck_pins_o = sck_en_q & {N_SCK{sck_q}};
  assign spi_mosi_oe_o = mosi_en_q;
  assign spi_mosi_pins_o = mosi_en_q & {N_MOSI{mosi_q}};

endmodule // p1m_pin_function_select

// ### p1m_pkg.sv
// p1m_pkg: constants, types and register map of the port-1 serial pin function select block.
// assumes a 32-bit AXI4-Lite register bus and registers placed one per aligned word.
package p1m_pkg;

  localparam int AXI_AW = 32;
  localparam int AXI_DW = 32;

  // register indices; byte address is four times the index
  localparam logic [AXI_AW-1:0] IDX_PIN0_FUNC = 32'h0000A058;
  localparam logic [AXI_AW-1:0] IDX_PIN1_FUNC = 32'h0000A059;
  localparam logic [AXI_AW-1:0] IDX_ROUTE_SEL = 32'h0000A0F0;
  localparam logic [AXI_AW-1:0] IDX_ROUTE_STAT = 32'h0000A0F1;

  // function select fields
  localparam int FN_GPIO_BIT = 0;
  localparam int FN_STD_BIT = 5;
  localparam int FN_LIN_BIT = 6;
  localparam logic [7:0] FN_RESET = 8'h00;
  localparam logic [7:0] FN_MASK = 8'h61;

  // peripheral route select fields
  localparam int RS_PWM_A_LSB = 0;
  localparam int RS_PWM_B_LSB = 4;
  localparam int RS_SCK_LSB = 8;
  localparam int RS_MOSI_LSB = 12;
  localparam int RS_MISO_LSB = 16;
  localparam int RS_SSN_LSB = 20;
  localparam logic [31:0] RS_RESET = 32'h00333777;
  localparam logic [31:0] RS_MASK = 32'h00333777;

  // candidate counts per routed signal
  localparam int N_PWM_A = 5;
  localparam int N_PWM_B = 5;
  localparam int N_SCK = 4;
  localparam int N_MOSI = 3;
  localparam int N_MISO = 3;
  localparam int N_SSN = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RT_TOUCH, RT_GPIO, RT_STD, RT_LIN} p1m_route_e;

  typedef struct packed {
    logic out;
    logic oe;
  } p1m_pin_drive_s;

endpackage

// ### p1m_pin_function_select_asserts.sv
// p1m_pin_function_select_asserts: port-level checks of the pin function select block.
// assumes binding onto p1m_pin_function_select with one clock domain.
`timescale 1ns/100ps
module p1m_pin_function_select_asserts
  import p1m_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [AXI_DW-1:0] s_axi_rdata_o,
  input wire logic std_serial_rx_o,
  input wire logic lin_serial_rx_o,
  input wire logic [1:0] gpio_in_o,
  input wire logic [1:0] touch_sense_o,
  input wire logic [N_PWM_A-1:0] pulse_a_oe_o,
  input wire logic [N_PWM_B-1:0] pulse_b_oe_o,
  input wire logic [N_SCK-1:0] spi_sck_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped early");
  a_bvalid_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  a_write_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
  a_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken during response");
  a_rx_single: assert property (std_serial_rx_o || lin_serial_rx_o)
    else $error("pin feeds both receivers");
  a_touch_io: assert property ((touch_sense_o & gpio_in_o) == 2'h0)
    else $error("touch and io both active");
  a_pulse_a_one: assert property ($onehot0(pulse_a_oe_o))
    else $error("pulse a on several pins");
  a_pulse_b_one: assert property ($onehot0(pulse_b_oe_o))
    else $error("pulse b on several pins");
  a_sck_one: assert property ($onehot0(spi_sck_oe_o))
    else $error("spi clock on several pins");
endmodule // p1m_pin_function_select_asserts

bind p1m_pin_function_select p1m_pin_function_select_asserts chk (.sys_clk_i, .rst_i, .s_axi_awready_o,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .std_serial_rx_o, .lin_serial_rx_o, .gpio_in_o, .touch_sense_o, .pulse_a_oe_o,
  .pulse_b_oe_o, .spi_sck_oe_o);

// ### p1m_far_side.sv
// p1m_far_side: package pins and serial transmitters facing the block.
// assumes pin 1 has a pull-up; pin 0 is driven from outside unless the block drives it.
`timescale 1ns/100ps
module p1m_far_side
  import p1m_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pin0_lvl_i,
  input wire p1m_pin_drive_s pin0_drv_i,
  input wire p1m_pin_drive_s pin1_drv_i,
  output logic pin0_o,
  output logic pin1_o,
  output logic std_tx_o,
  output logic lin_tx_o
);
  assign pin0_o = pin0_drv_i.oe ? pin0_drv_i.out : pin0_lvl_i;
  assign pin1_o = pin1_drv_i.oe ? pin1_drv_i.out : 1'h1;
  // transmitters toggle every cycle so a stale or swapped source shows
  assign lin_tx_o = ~std_tx_o;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      std_tx_o <= 1'h0;
    else
      std_tx_o <= ~std_tx_o;
  end
endmodule // p1m_far_side

// ### p1m_pin_function_select_bench.sv
// p1m_pin_function_select_bench: self-checking bench of the port-1 pin function select block.
// assumes p1m_pkg, the far-side model and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; $display("BAD %s exp %0h got %0h", n, e, a); end end
module p1m_pin_function_select_bench;
  import p1m_pkg::*;
  logic sys_clk_i = '0, rst_i = '1, lvl0 = '1;
  logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = '1, spi_sck_pins_o, spi_sck_oe_o;
  logic s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0, s_axi_arvalid_i = '0, s_axi_rready_i = '0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, gpio_in_o, touch_sense_o, gpio_out_i = '0, gpio_oe_i = '0;
  logic p1_pin0_i, p1_pin1_i, std_serial_tx_i, lin_serial_tx_i, std_serial_rx_o, lin_serial_rx_o;
  logic pulse_output_a_i = '0, pulse_output_b_i = '0, spi_sck_i = '0, spi_mosi_i = '0, spi_miso_o, spi_ssn_n_o;
  logic [4:0] pulse_a_pins_o, pulse_a_oe_o, pulse_b_pins_o, pulse_b_oe_o;
  logic [2:0] spi_mosi_pins_o, spi_mosi_oe_o, spi_miso_pins_i = '0;
  logic [1:0] spi_ssn_n_pins_i = '1;
  p1m_pin_drive_s p1_pin0_o, p1_pin1_o;
  int fail_count = 0, num_checks = 0;
  p1m_pin_function_select dut (.sys_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .p1_pin0_i, .p1_pin0_o, .p1_pin1_i, .p1_pin1_o, .std_serial_rx_o,
    .std_serial_tx_i, .lin_serial_rx_o, .lin_serial_tx_i, .gpio_out_i, .gpio_oe_i, .gpio_in_o, .touch_sense_o,
    .pulse_output_a_i, .pulse_output_b_i, .pulse_a_pins_o, .pulse_a_oe_o, .pulse_b_pins_o, .pulse_b_oe_o,
    .spi_sck_i, .spi_mosi_i, .spi_sck_pins_o, .spi_sck_oe_o, .spi_mosi_pins_o, .spi_mosi_oe_o,
    .spi_miso_pins_i, .spi_miso_o, .spi_ssn_n_pins_i, .spi_ssn_n_o);
  p1m_far_side far (.sys_clk_i, .rst_i, .pin0_lvl_i(lvl0), .pin0_drv_i(p1_pin0_o), .pin1_drv_i(p1_pin1_o),
    .pin0_o(p1_pin0_i), .pin1_o(p1_pin1_i), .std_tx_o(std_serial_tx_i), .lin_tx_o(lin_serial_tx_i));
  always #20 sys_clk_i = ~sys_clk_i;

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 50)
    begin
      `CHK("wait", 1'h0, 1'h1)
      conclude();
    end
  endtask

  // ready is sampled at the falling edge, so the release lands right after the taking edge
  task automatic wr(input logic [31:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic a, w, b;
    logic [1:0] r;
    b = 1'h0;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= idx << 2;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    for (n = 0; n < 50 && !b; n++)
    begin
      @(negedge sys_clk_i);
      a = s_axi_awvalid_i && s_axi_awready_o;
      w = s_axi_wvalid_i && s_axi_wready_o;
      b = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge sys_clk_i);
      if (a) s_axi_awvalid_i <= 1'h0;
      if (w) s_axi_wvalid_i <= 1'h0;
    end
    s_axi_bready_i <= 1'h0;
    tmo(n);
    `CHK("bresp", er, r)
  endtask

  task automatic rd(input logic [31:0] idx, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic a, v;
    logic [31:0] d;
    logic [1:0] r;
    v = 1'h0;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= idx << 2;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    for (n = 0; n < 50 && !v; n++)
    begin
      @(negedge sys_clk_i);
      a = s_axi_arvalid_i && s_axi_arready_o;
      v = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge sys_clk_i);
      if (a) s_axi_arvalid_i <= 1'h0;
    end
    s_axi_rready_i <= 1'h0;
    tmo(n);
    `CHK("rdata", e, d)
    `CHK("rresp", er, r)
  endtask

  task automatic settle;
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic t_reset;
    rd(IDX_PIN0_FUNC, 32'h0, RESP_OKAY);
    rd(IDX_PIN1_FUNC, 32'h0, RESP_OKAY);
    settle();
    `CHK("pin1 oe", 1'h0, p1_pin1_o.oe)
    `CHK("io in", 2'h0, gpio_in_o)
    `CHK("touch", 2'h3, touch_sense_o)
    `CHK("std rx", 1'h1, std_serial_rx_o)
    $display("test reset done");
  endtask

  task automatic t_std;
    wr(IDX_PIN0_FUNC, 32'h20, RESP_OKAY);
    wr(IDX_PIN1_FUNC, 32'h20, RESP_OKAY);
    rd(IDX_PIN0_FUNC, 32'h20, RESP_OKAY);
    lvl0 <= 1'h0;
    settle();
    `CHK("std rx", 1'h0, std_serial_rx_o)
    `CHK("lin rx", 1'h1, lin_serial_rx_o)
    `CHK("pin1 oe", 1'h1, p1_pin1_o.oe)
    `CHK("pin1 out", ~std_serial_tx_i, p1_pin1_o.out)
    `CHK("touch", 2'h0, touch_sense_o)
    rd(IDX_ROUTE_STAT, 32'hA, RESP_OKAY);
    $display("test standard done");
  endtask

  task automatic t_lin;
    wr(IDX_PIN0_FUNC, 32'h40, RESP_OKAY);
    wr(IDX_PIN1_FUNC, 32'h40, RESP_OKAY);
    settle();
    `CHK("lin rx", 1'h0, lin_serial_rx_o)
    `CHK("std rx", 1'h1, std_serial_rx_o)
    `CHK("pin1 out", ~lin_serial_tx_i, p1_pin1_o.out)
    lvl0 <= 1'h1;
    settle();
    `CHK("lin rx", 1'h1, lin_serial_rx_o)
    $display("test lin done");
  endtask

  task automatic t_gpio;
    wr(IDX_PIN0_FUNC, 32'hFF, RESP_OKAY);
    rd(IDX_PIN0_FUNC, 32'h61, RESP_OKAY);
    wr(IDX_PIN0_FUNC, 32'h01, RESP_OKAY);
    wr(IDX_PIN1_FUNC, 32'h01, RESP_OKAY);
    s_axi_wstrb_i <= 4'hE;
    wr(IDX_PIN1_FUNC, 32'h20, RESP_OKAY);
    s_axi_wstrb_i <= 4'hF;
    wr(IDX_ROUTE_STAT, 32'hF, RESP_OKAY);
    gpio_oe_i <= 2'h2;
    gpio_out_i <= 2'h2;
    settle();
    `CHK("io in", 2'h3, gpio_in_o)
    `CHK("touch", 2'h0, touch_sense_o)
    `CHK("pin1 drive", 2'h3, p1_pin1_o)
    `CHK("pin0 drive", 2'h0, p1_pin0_o)
    `CHK("std rx", 1'h1, std_serial_rx_o)
    rd(IDX_ROUTE_STAT, 32'h5, RESP_OKAY);
    $display("test io done");
  endtask

  task automatic t_route;
    pulse_output_a_i <= 1'h1;
    pulse_output_b_i <= 1'h1;
    spi_sck_i <= 1'h1;
    spi_mosi_i <= 1'h1;
    spi_miso_pins_i <= 3'h2;
    spi_ssn_n_pins_i <= 2'h2;
    settle();
    `CHK("pulse a oe", 5'h00, pulse_a_oe_o)
    `CHK("miso", 1'h0, spi_miso_o)
    `CHK("ssn", 1'h1, spi_ssn_n_o)
    wr(IDX_ROUTE_SEL, 32'h00333132, RESP_OKAY);
    settle();
    `CHK("pulse a oe", 5'h04, pulse_a_oe_o)
    `CHK("pulse a pins", 5'h04, pulse_a_pins_o)
    `CHK("pulse b oe", 5'h08, pulse_b_oe_o)
    `CHK("pulse b pins", 5'h08, pulse_b_pins_o)
    `CHK("sck oe", 4'h2, spi_sck_oe_o)
    `CHK("sck pins", 4'h2, spi_sck_pins_o)
    `CHK("mosi oe", 3'h0, spi_mosi_oe_o)
    wr(IDX_ROUTE_SEL, 32'h00012132, RESP_OKAY);
    settle();
    `CHK("mosi oe", 3'h4, spi_mosi_oe_o)
    `CHK("mosi pins", 3'h4, spi_mosi_pins_o)
    `CHK("miso", 1'h1, spi_miso_o)
    `CHK("ssn", 1'h0, spi_ssn_n_o)
    wr(32'h0, 32'h1, RESP_SLVERR);
    rd(32'h0, 32'h0, RESP_SLVERR);
    $display("test route done");
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_std();
    t_lin();
    t_gpio();
    t_route();
    conclude();
  end
endmodule // p1m_pin_function_select_bench
